// *** verilog/tarf_pkg.sv ***
// constants and types shared by the theft alarm relock logic
`default_nettype none
package tarf_pkg;
  // ************************************
  // timing
  // ************************************
  localparam int CLK_HZ           = 100_000_000;
  localparam int FLASH_HALF_MS    = 500;
  localparam int HALF_SEC_CYC     = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int TICKS_PER_SEC    = 1000 / FLASH_HALF_MS;
  localparam int ALARM_ON_S       = 27;
  localparam int ALARM_GAP_S      = 10;
  localparam int ALARM_ON_TICKS   = ALARM_ON_S * TICKS_PER_SEC;
  localparam int ALARM_END_TICKS  = (ALARM_ON_S + ALARM_GAP_S) * TICKS_PER_SEC;
  localparam int FLASH_PHASES     = 4;
  localparam int RELOCK_CLOSED_TK = 60;
  localparam int RELOCK_OPEN_TK   = 60;
  // ************************************
  // register map
  // ************************************
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hc;
  localparam int CTRL_SMART_BIT = 0;
  localparam int STAT_HOOD_BIT  = 3;
  localparam int STAT_TRUNK_BIT = 4;
  localparam int STAT_FLASH_BIT = 5;
  localparam int STAT_INH_BIT   = 6;
  localparam int STAT_HORN_BIT  = 7;
  localparam int IRQ_LOCK_BIT   = 0;
  localparam int IRQ_ALARM_BIT  = 1;
  localparam int IRQ_UNLOCK_BIT = 2;
  localparam int IRQ_W          = 3;
  localparam logic       CTRL_RESET = 1'b0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // ************************************
  // states
  // ************************************
  typedef enum logic [2:0] {
    ST_UNGUARDED,
    ST_ARMED,
    ST_ARMING_DELAY,
    ST_PRE_ARMED,
    ST_ALARM,
    ST_RETURN_TO_ARMED,
    ST_RELOCK_CLOSED,
    ST_RELOCK_OPEN
  } tarf_state_t;
endpackage : tarf_pkg
`default_nettype wire

// *** verilog/tarf_countdown.sv ***
// tick-driven countdown with restart and one-cycle expiry pulse
`default_nettype none
module tarf_countdown #(
  parameter int LOAD = 60
) (
  input  wire logic clock,   // system clock
  input  wire logic reset,   // sync reset, high
  input  wire logic tick,    // half-second enable
  input  wire logic start,   // (re)load and run
  input  wire logic cancel,  // stop without expiry
  output logic      running, // counting
  output logic      expired  // one-cycle pulse at end
);
  localparam int W = $clog2(LOAD + 1);
  // refused at elaboration: a zero load would never expire
  if (LOAD < 1)
  begin : g_bad_load
    $error("countdown load must be at least one tick");
  end
  logic [W-1:0] cnt_ff;
  logic         run_ff;
  logic         exp_ff;
  // restart wins over expiry in the same cycle
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end
    else
    begin
      exp_ff <= 1'b0;
      if (start)
      begin
        cnt_ff <= W'(LOAD);
        run_ff <= 1'b1;
      end
      else if (cancel)
        run_ff <= 1'b0;
      else if (run_ff && tick)
      begin
        if (cnt_ff == W'(1))
        begin
          run_ff <= 1'b0;
          exp_ff <= 1'b1;
        end
        cnt_ff <= cnt_ff - W'(1);
      end
    end
  end
  assign running = run_ff;
  assign expired = exp_ff;
endmodule : tarf_countdown
`default_nettype wire

// *** verilog/tarf_relock_fsm.sv ***
// theft alarm: alarm exit, re-arm and automatic relock countdowns
//
// Local design decisions: the plain strobed port and the placing of the registers.
`default_nettype none
module tarf_relock_fsm #(
  parameter int HALF_SEC_CYCLES = tarf_pkg::HALF_SEC_CYC,
  parameter int CLOSED_TICKS    = tarf_pkg::RELOCK_CLOSED_TK,
  parameter int OPEN_TICKS      = tarf_pkg::RELOCK_OPEN_TK
) (
  input  wire logic        clock,          // 100 MHz
  input  wire logic        reset,          // sync reset, high
  input  wire logic        doors_closed,   // pin: all doors closed
  input  wire logic        hood_closed,    // pin: hood switch closed
  input  wire logic        trunk_closed,   // pin: trunk switch closed
  input  wire logic        ignition_key_removed, // pin
  input  wire logic        tx_unlock,      // pin: transmitter unlock
  input  wire logic        keyless_unlock_command, // pin: smart key unlock
  input  wire logic        passive_unlock, // pin: passive entry unlock
  input  wire logic        goto_valid,     // other logic: force state
  input  wire logic [2:0]  goto_state,     // target state code
  input  wire logic [3:0]  addr,           // register address
  input  wire logic [31:0] wdata,          // write data
  input  wire logic        wr,             // write strobe
  input  wire logic        rd,             // read strobe
  output logic      [31:0] rdata,          // read data, cycle after rd
  output logic             irq,            // level interrupt
  output logic             hazard_relay,   // hazard lamps
  output logic             horn_relay,     // horn
  output logic             start_inhibit,  // start-inhibit relay
  output logic             auto_lock,      // one-cycle lock request
  output logic             closed_started, // closed countdown start pulse
  output logic             open_started,   // open countdown start pulse
  output logic       [2:0] state_code      // current state
);
  // refused at elaboration: the tick divider needs at least two cycles
  if (HALF_SEC_CYCLES < 2)
  begin : g_bad_half_sec
    $error("half-second count too small");
  end
  localparam int HW = $clog2(HALF_SEC_CYCLES);
  localparam int AW = $clog2(tarf_pkg::ALARM_END_TICKS + 1);

  // ************************************
  // pin synchronisers
  // ************************************
  logic [6:0] pin_s1_ff;
  logic [6:0] pin_s2_ff;
  logic [2:0] cmd_prev_ff;
  always_ff @(posedge clock)
  begin
    pin_s1_ff <= {doors_closed, hood_closed, trunk_closed, ignition_key_removed,
                  tx_unlock, keyless_unlock_command, passive_unlock};
    pin_s2_ff <= pin_s1_ff;
  end
  wire logic doors_c = pin_s2_ff[6];
  wire logic hood_c  = pin_s2_ff[5];
  wire logic trunk_c = pin_s2_ff[4];
  wire logic key_out = pin_s2_ff[3];
  wire logic all_closed = doors_c & hood_c & trunk_c;
  always_ff @(posedge clock)
  begin
    if (reset)
      cmd_prev_ff <= 3'h7;
    else
      cmd_prev_ff <= pin_s2_ff[2:0];
  end
  wire logic [2:0] cmd_rise = pin_s2_ff[2:0] & ~cmd_prev_ff;

  // ************************************
  // registers
  // ************************************
  logic             smart_ff;
  logic [tarf_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [tarf_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [31:0]               rdata_ff;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      smart_ff    <= tarf_pkg::CTRL_RESET;
      irq_mask_ff <= tarf_pkg::MASK_RESET;
    end
    else if (wr && addr == tarf_pkg::REG_CTRL)
      smart_ff <= wdata[tarf_pkg::CTRL_SMART_BIT];
    else if (wr && addr == tarf_pkg::REG_IRQ_MASK)
      irq_mask_ff <= wdata[tarf_pkg::IRQ_W-1:0];
  end

  // smart key variant chooses which unlock source counts
  wire logic unlock = smart_ff ? (cmd_rise[1] | cmd_rise[0]) : cmd_rise[2];

  // ************************************
  // half-second tick
  // ************************************
  logic [HW-1:0] div_ff;
  logic          tick;
  always_ff @(posedge clock)
  begin
    if (reset || div_ff == HW'(HALF_SEC_CYCLES - 1))
      div_ff <= '0;
    else
      div_ff <= div_ff + HW'(1);
  end
  assign tick = (div_ff == HW'(HALF_SEC_CYCLES - 1));

  // ************************************
  // state machine
  // ************************************
  tarf_pkg::tarf_state_t state_ff;
  tarf_pkg::tarf_state_t nxt_state;
  logic start_closed;
  logic start_open;
  logic closed_exp;
  logic open_exp;
  logic alarm_done;
  always_comb
  begin
    nxt_state    = state_ff;
    start_closed = 1'b0;
    start_open   = 1'b0;
    case (state_ff)
      tarf_pkg::ST_ARMED, tarf_pkg::ST_ARMING_DELAY, tarf_pkg::ST_RETURN_TO_ARMED:
        if (unlock)
          start_closed = 1'b1;
      tarf_pkg::ST_UNGUARDED:
        if (unlock && key_out && all_closed)
          start_closed = 1'b1;
        else if (unlock && key_out && !(hood_c && trunk_c))
          start_open = 1'b1;
      tarf_pkg::ST_ALARM:
        if (unlock && all_closed)
          start_closed = 1'b1;
        else if (all_closed && alarm_done)
          nxt_state = tarf_pkg::ST_RETURN_TO_ARMED;
      tarf_pkg::ST_RELOCK_CLOSED:
        start_closed = unlock;
      tarf_pkg::ST_RELOCK_OPEN:
        start_open = unlock;
      default:
        nxt_state = state_ff;
    endcase
    if (start_closed)
      nxt_state = tarf_pkg::ST_RELOCK_CLOSED;
    else if (start_open)
      nxt_state = tarf_pkg::ST_RELOCK_OPEN;
    else if (goto_valid && nxt_state == state_ff)
      nxt_state = tarf_pkg::tarf_state_t'(goto_state);
  end
  always_ff @(posedge clock)
  begin
    if (reset)
      state_ff <= tarf_pkg::ST_UNGUARDED;
    else
      state_ff <= nxt_state;
  end
  wire logic leave_alarm = (state_ff == tarf_pkg::ST_ALARM) && start_closed;
  wire logic enter_alarm = (state_ff != tarf_pkg::ST_ALARM) && (nxt_state == tarf_pkg::ST_ALARM);

  // ************************************
  // hood and trunk memo
  // ************************************
  logic hood_memo_ff;
  logic trunk_memo_ff;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      hood_memo_ff  <= 1'b0;
      trunk_memo_ff <= 1'b0;
    end
    else if (start_open && state_ff == tarf_pkg::ST_UNGUARDED)
    begin
      hood_memo_ff  <= hood_c;
      trunk_memo_ff <= trunk_c;
    end
  end

  // ************************************
  // relock countdowns
  // ************************************
  logic closed_run;
  logic open_run;
  // each countdown has its own length, lengths not tied together
  tarf_countdown #(.LOAD(CLOSED_TICKS)) u_closed (
    .clock   (clock),
    .reset   (reset),
    .tick    (tick),
    .start   (start_closed),
    .cancel  (nxt_state != tarf_pkg::ST_RELOCK_CLOSED),
    .running (closed_run),
    .expired (closed_exp)
  );
  tarf_countdown #(.LOAD(OPEN_TICKS)) u_open (
    .clock   (clock),
    .reset   (reset),
    .tick    (tick),
    .start   (start_open),
    .cancel  (nxt_state != tarf_pkg::ST_RELOCK_OPEN),
    .running (open_run),
    .expired (open_exp)
  );
  logic lock_ff;
  always_ff @(posedge clock)
  begin
    if (reset)
      lock_ff <= 1'b0;
    else
      lock_ff <= closed_exp | open_exp;
  end

  // ************************************
  // double hazard flash
  // ************************************
  // own phase timer so every flash gets full 0.5 s phases
  logic [HW-1:0] fl_cnt_ff;
  logic [2:0]    fl_phase_ff;
  wire logic     flash_busy = fl_phase_ff != 3'(tarf_pkg::FLASH_PHASES);
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      fl_cnt_ff   <= '0;
      fl_phase_ff <= 3'(tarf_pkg::FLASH_PHASES);
    end
    else if (start_closed || start_open)
    begin
      fl_cnt_ff   <= '0;
      fl_phase_ff <= 3'h0;
    end
    else if (flash_busy)
    begin
      if (fl_cnt_ff == HW'(HALF_SEC_CYCLES - 1))
      begin
        fl_cnt_ff   <= '0;
        fl_phase_ff <= fl_phase_ff + 3'h1;
      end
      else
        fl_cnt_ff <= fl_cnt_ff + HW'(1);
    end
  end
  wire logic flash_on = flash_busy && !fl_phase_ff[0];

  // ************************************
  // alarm sequence and relays
  // ************************************
  logic [AW-1:0] al_cnt_ff;
  logic          inh_ff;
  logic          horn_on;
  always_ff @(posedge clock)
  begin
    if (reset || enter_alarm)
      al_cnt_ff <= '0;
    else if (state_ff == tarf_pkg::ST_ALARM && tick && !alarm_done)
      al_cnt_ff <= al_cnt_ff + AW'(1);
  end
  assign alarm_done = al_cnt_ff == AW'(tarf_pkg::ALARM_END_TICKS);
  assign horn_on = (state_ff == tarf_pkg::ST_ALARM)
                 && al_cnt_ff < AW'(tarf_pkg::ALARM_ON_TICKS);
  always_ff @(posedge clock)
  begin
    if (reset)
      inh_ff <= 1'b0;
    else if (enter_alarm)
      inh_ff <= 1'b1;
    else if (start_closed && (state_ff == tarf_pkg::ST_ALARM
             || state_ff == tarf_pkg::ST_RETURN_TO_ARMED))
      inh_ff <= 1'b0;
  end
  logic horn_ff;
  logic haz_ff;
  always_ff @(posedge clock)
  begin
    if (reset || leave_alarm)
    begin
      horn_ff <= 1'b0;
      haz_ff  <= 1'b0;
    end
    else
    begin
      horn_ff <= horn_on;
      haz_ff  <= horn_on | flash_on;
    end
  end

  // ************************************
  // interrupts and read port
  // ************************************
  wire logic [2:0] irq_ev = {start_closed | start_open, enter_alarm, lock_ff};
  always_ff @(posedge clock)
  begin
    if (reset)
      irq_stat_ff <= '0;
    else if (rd && addr == tarf_pkg::REG_IRQ_STAT)
      irq_stat_ff <= irq_ev; // events of this cycle survive the clear
    else
      irq_stat_ff <= irq_stat_ff | irq_ev;
  end
  always_ff @(posedge clock)
  begin
    if (reset)
      rdata_ff <= '0;
    else if (rd)
      case (addr)
        tarf_pkg::REG_CTRL:     rdata_ff <= {31'h0, smart_ff};
        tarf_pkg::REG_STATUS:   rdata_ff <= {24'h0, horn_ff, inh_ff, flash_busy,
                                             trunk_memo_ff, hood_memo_ff, state_ff};
        tarf_pkg::REG_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
        tarf_pkg::REG_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
        default:                rdata_ff <= 32'h0;
      endcase
    else
      rdata_ff <= 32'h0;
  end
  logic closed_st_ff;
  logic open_st_ff;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      closed_st_ff <= 1'b0;
      open_st_ff   <= 1'b0;
    end
    else
    begin
      closed_st_ff <= start_closed;
      open_st_ff   <= start_open;
    end
  end
  assign rdata          = rdata_ff;
  assign irq            = |(irq_stat_ff & irq_mask_ff);
  assign hazard_relay   = haz_ff;
  assign horn_relay     = horn_ff;
  assign start_inhibit  = inh_ff;
  assign auto_lock      = lock_ff;
  assign closed_started = closed_st_ff;
  assign open_started   = open_st_ff;
  assign state_code     = state_ff;

  // ************************************
  // checks
  // ************************************
  return_to_armed_entry_a: assert property (@(posedge clock) disable iff (reset)
    state_ff == tarf_pkg::ST_ALARM && all_closed && alarm_done && !unlock
    |=> state_ff == tarf_pkg::ST_RETURN_TO_ARMED)
    else $error("alarm did not re-arm");
  flash_width_a: assert property (@(posedge clock) disable iff (reset)
    $rose(flash_on) |=> flash_on [*8])
    else $error("flash pulse too short");
  armed_unlock_a: assert property (@(posedge clock) disable iff (reset)
    unlock && state_ff == tarf_pkg::ST_ARMED
    |=> state_ff == tarf_pkg::ST_RELOCK_CLOSED && closed_started)
    else $error("armed unlock missed");
  unguard_closed_a: assert property (@(posedge clock) disable iff (reset)
    unlock && key_out && all_closed && state_ff == tarf_pkg::ST_UNGUARDED
    |=> state_ff == tarf_pkg::ST_RELOCK_CLOSED)
    else $error("unguarded closed unlock missed");
  alarm_unlock_a: assert property (@(posedge clock) disable iff (reset)
    unlock && all_closed && state_ff == tarf_pkg::ST_ALARM
    |=> state_ff == tarf_pkg::ST_RELOCK_CLOSED ##1 !horn_relay && !start_inhibit)
    else $error("alarm unlock missed");
  inhibit_off_a: assert property (@(posedge clock) disable iff (reset)
    unlock && state_ff == tarf_pkg::ST_RETURN_TO_ARMED |=> !start_inhibit)
    else $error("start inhibit stayed on");
  lock_pulse_a: assert property (@(posedge clock) disable iff (reset)
    closed_exp |=> auto_lock && $stable(state_ff))
    else $error("closed expiry did not lock");
  open_lock_a: assert property (@(posedge clock) disable iff (reset)
    open_exp && !goto_valid |=> auto_lock && state_ff == tarf_pkg::ST_RELOCK_OPEN)
    else $error("open expiry did not lock");
  open_entry_a: assert property (@(posedge clock) disable iff (reset)
    start_open && state_ff == tarf_pkg::ST_UNGUARDED
    |=> state_ff == tarf_pkg::ST_RELOCK_OPEN && hood_memo_ff == $past(hood_c)
        && trunk_memo_ff == $past(trunk_c))
    else $error("open entry or memo wrong");
  restart_a: assert property (@(posedge clock) disable iff (reset)
    unlock && state_ff == tarf_pkg::ST_RELOCK_CLOSED
    |=> closed_run && closed_started && state_ff == tarf_pkg::ST_RELOCK_CLOSED)
    else $error("closed countdown not restarted");
endmodule : tarf_relock_fsm
`default_nettype wire

// *** testbench/tarf_vehicle.sv ***
// far-side model: body switches, ignition key and unlock receivers
`default_nettype none
module tarf_vehicle (
  input  wire logic       clock,                // bench clock
  input  wire logic [2:0] press,                // one-hot: tx, keyless, passive
  input  wire logic       slow,                 // long button press
  input  wire logic [3:0] want,                 // doors, hood, trunk, key out
  output var  logic       doors_closed,         // high when closed
  output var  logic       hood_closed,          // high when closed
  output var  logic       trunk_closed,         // high when closed
  output var  logic       ignition_key_removed, // high when key out
  output var  logic [2:0] cmd                   // unlock lines, idle low
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold [3] = '{0, 0, 0};
  initial
  begin
    {doors_closed, hood_closed, trunk_closed, ignition_key_removed} = 4'h0;
    cmd = 3'h0;
  end
  // a press lasts 3 or 6 cycles so the receiver sees exactly one rising edge
  always @(posedge clock)
  begin
    {doors_closed, hood_closed, trunk_closed, ignition_key_removed} <= want;
    for (int i = 0; i < 3; i++)
    begin
      if (press[i])
        hold[i] <= slow ? 6 : 3;
      else if (hold[i] > 0)
        hold[i] <= hold[i] - 1;
      cmd[i] <= press[i] || hold[i] > 1;
    end
  end
endmodule : tarf_vehicle
`default_nettype wire

// *** testbench/theft_alarm_relock_fsm_bench.sv ***
// self-checking bench for the relock and alarm-exit state machine
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module theft_alarm_relock_fsm_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H    = 10;
  localparam int NC   = 8;
  localparam int NO   = 7;
  localparam int AON  = tarf_pkg::ALARM_ON_TICKS;
  localparam int AGAP = tarf_pkg::ALARM_END_TICKS - AON;
  logic        clock = 1'b0;
  logic        reset, goto_valid, wr, rd, slow, irq, hazard_relay, horn_relay;
  logic        start_inhibit, auto_lock, closed_started, open_started;
  logic        doors_closed, hood_closed, trunk_closed, ignition_key_removed;
  logic [2:0]  press, cmd, goto_state, state_code;
  logic [3:0]  want, addr;
  logic [31:0] wdata, rdata, d, wv;
  int          n_fail, n_checks, seed, m_state, m_smart, m_inh, since, lock_gap, n_locks;
  always #5 clock = ~clock;
  tarf_vehicle tarf_vehicle_inst (.clock(clock), .press(press), .slow(slow), .want(want),
    .doors_closed(doors_closed), .hood_closed(hood_closed), .trunk_closed(trunk_closed),
    .ignition_key_removed(ignition_key_removed), .cmd(cmd));
  tarf_relock_fsm #(.HALF_SEC_CYCLES(H), .CLOSED_TICKS(NC), .OPEN_TICKS(NO)) tarf_relock_fsm_inst (
    .clock(clock), .reset(reset), .doors_closed(doors_closed), .hood_closed(hood_closed),
    .trunk_closed(trunk_closed), .ignition_key_removed(ignition_key_removed),
    .tx_unlock(cmd[0]), .keyless_unlock_command(cmd[1]), .passive_unlock(cmd[2]),
    .goto_valid(goto_valid), .goto_state(goto_state), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .hazard_relay(hazard_relay), .horn_relay(horn_relay),
    .start_inhibit(start_inhibit), .auto_lock(auto_lock), .closed_started(closed_started),
    .open_started(open_started), .state_code(state_code));
  // cycles from the latest countdown start to each lock pulse
  always @(posedge clock)
  begin
    since <= (closed_started || open_started) ? 0 : since + 1;
    if (auto_lock === 1'b1)
    begin
      lock_gap <= since;
      n_locks <= n_locks + 1;
    end
  end
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    v = rdata;
  endtask : rd_reg
  task go(input int st);
    @(posedge clock);
    goto_valid <= 1'b1;
    goto_state <= 3'(st);
    @(posedge clock);
    goto_valid <= 1'b0;
    @(negedge clock);
    m_state = st;
    m_inh = (st == 4) ? 1 : m_inh;
    `CHK(state_code, 3'(st))
  endtask : go
  task env(input logic [3:0] w);
    @(posedge clock);
    want <= w;
    repeat (6) @(posedge clock);
  endtask : env
  // expected target of an accepted unlock, -1 when it must be ignored
  function automatic int nxt(input int st, input int src);
    logic allc;
    allc = &want[3:1];
    if (m_smart ? src == 0 : src != 0)
      return -1;
    case (st)
      1, 2, 5: return 6;
      4: return allc ? 6 : -1;
      6, 7: return st;
      0: return !want[0] ? -1 : allc ? 6 : (!want[2] || !want[1]) ? 7 : -1;
      default: return -1;
    endcase
  endfunction : nxt
  task unlock(input int src, input bit flash);
    int   nx, k;
    logic sc, so;
    nx = nxt(m_state, src);
    sc = 1'b0;
    so = 1'b0;
    @(posedge clock);
    press <= 3'b001 << src;
    slow <= 1'($random(seed));
    @(posedge clock);
    press <= 3'b000;
    for (k = 0; k < 12 && !(sc || so); k++)
    begin
      @(negedge clock);
      sc = closed_started;
      so = open_started;
    end
    `CHK(sc, logic'(nx == 6))
    `CHK(so, logic'(nx == 7))
    if (nx >= 0 && flash)
      for (k = 0; k <= 4 * H; k++)
      begin
        @(negedge clock);
        `CHK(hazard_relay, logic'(k < 4 * H && (k / H) % 2 == 0))
      end
    if (nx >= 0)
    begin
      m_inh = (m_state == 4 || m_state == 5) ? 0 : m_inh;
      m_state = nx;
      `CHK(horn_relay, 1'b0)
    end
    `CHK(state_code, 3'(m_state))
    `CHK(start_inhibit, logic'(m_inh != 0))
  endtask : unlock
  task wait_lock(input int n);
    int c0, k;
    c0 = n_locks;
    for (k = 0; k < (n + 2) * H && n_locks == c0; k++)
      @(negedge clock);
    `CHK(n_locks, c0 + 1)
    `CHK(lock_gap >= (n - 1) * H - 2 && lock_gap <= n * H + 2, 1'b1)
    `CHK(state_code, 3'(m_state))
  endtask : wait_lock
  initial
  begin
    repeat (40000) @(posedge clock);
    n_fail++;
    $display("watchdog expired");
    results();
  end
  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    int k, sts [3];
    {reset, goto_valid, wr, rd, slow, press, goto_state, want, addr, wdata} = '0;
    reset = 1'b1;
    {n_fail, n_checks, m_state, m_smart, m_inh, since, lock_gap, n_locks} = '0;
    seed = 30;
    sts = '{1, 2, 5};
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    `CHK(state_code, 3'd0)
    `CHK({hazard_relay, horn_relay, start_inhibit, irq, auto_lock}, 5'h00)
    rd_reg(tarf_pkg::REG_CTRL, d);
    `CHK(d, 32'h0)
    rd_reg(tarf_pkg::REG_IRQ_MASK, d);
    `CHK(d, 32'h0)
    rd_reg(4'h2, d);
    `CHK(d, 32'h0)
    wv = $random(seed);
    wr_reg(tarf_pkg::REG_IRQ_MASK, wv);
    rd_reg(tarf_pkg::REG_IRQ_MASK, d);
    `CHK(d, {29'h0, wv[2:0]})
    wr_reg(tarf_pkg::REG_IRQ_MASK, 32'h4);
    env(4'hf);
    unlock(0, 1);
    `CHK(irq, 1'b1)
    rd_reg(tarf_pkg::REG_IRQ_STAT, d);
    `CHK(d[2], 1'b1)
    @(negedge clock);
    `CHK(irq, 1'b0)
    unlock(0, 1);
    wait_lock(NC);
    env(4'he);
    go(0);
    unlock(0, 0);
    env(4'hb);
    go(0);
    unlock(0, 0);
    rd_reg(tarf_pkg::REG_STATUS, d);
    `CHK(d[4:3], {want[1], want[2]})
    unlock(0, 1);
    wait_lock(NO);
    env(4'hf);
    go(4);
    repeat (2) @(negedge clock);
    `CHK({horn_relay, start_inhibit}, 2'b11)
    unlock(0, 1);
    go(4);
    repeat (2) @(negedge clock);
    for (k = 0; k < (AON + 4) * H && horn_relay === 1'b1; k++)
    begin
      `CHK({hazard_relay, state_code}, 4'hc)
      @(negedge clock);
    end
    `CHK(k >= (AON - 1) * H - 4 && k <= AON * H + 2, 1'b1)
    for (k = 0; k < (AGAP + 4) * H && state_code !== 3'd5; k++)
    begin
      `CHK({hazard_relay, horn_relay}, 2'b00)
      @(negedge clock);
    end
    `CHK(k >= AGAP * H - 4 && k <= AGAP * H + 4, 1'b1)
    m_state = 5;
    unlock(0, 1);
    wr_reg(tarf_pkg::REG_CTRL, 32'h1);
    m_smart = 1;
    for (k = 0; k < 3; k++)
    begin
      go(sts[k]);
      unlock(0, 0);
      unlock(k == 1 ? 2 : 1, 0);
    end
    results();
  end
endmodule : theft_alarm_relock_fsm_bench
`default_nettype wire
